// ==== inc/csib_consts.vh ====
// Purpose: Shared constants of the charger status and interrupt bank
// Assumes: Included by bare name from the design file
// Notes: Register map offsets, field positions, reset values, timing
`ifndef CSIB_CONSTS_VH
`define CSIB_CONSTS_VH

// Register offsets on the register port
`define CSIB_ADDR_STATUS 8'h02
`define CSIB_ADDR_FLAGS0 8'h04
`define CSIB_ADDR_FLAGS1 8'h05
`define CSIB_ADDR_FLAGS2 8'h06
`define CSIB_ADDR_MASK0 8'h08

// Reset values
`define CSIB_FLAGS_RESET 8'h00
`define CSIB_MASK_RESET 8'h00
`define CSIB_STATUS_RESET 8'h00

// Status register field positions
`define CSIB_ST_SRCSEL 7
`define CSIB_ST_SRCOVP 6
`define CSIB_ST_TSHUT 5
`define CSIB_ST_TREG 4
`define CSIB_ST_TWIN 3
`define CSIB_ST_TUNSAFE 2
`define CSIB_ST_WDTO 1
`define CSIB_ST_SAFETO 0

// Charge and input flag positions
`define CSIB_F0_SOURCE_VALIDATION_FAIL 7
`define CSIB_F0_SECSRC 6
`define CSIB_F0_BUSSRC 5
`define CSIB_F0_GOODBAT 4
`define CSIB_F0_CHGDONE 3
`define CSIB_F0_PHASE 2
`define CSIB_F0_WEAKBAT 1
`define CSIB_F0_BATPRES 0

// Boost and charge flag positions
`define CSIB_F1_LOWCUR 7
`define CSIB_F1_RECHG 6
`define CSIB_F1_BOOST_OVERVOLTAGE 5
`define CSIB_F1_BSTOTP 4
`define CSIB_F1_BOOST_REGULATION_FAIL 3
`define CSIB_F1_BSTUV 2
`define CSIB_F1_BSTWD 1
`define CSIB_F1_BSTLOW 0

// Fault flag positions
`define CSIB_F2_TOPOFF 7
`define CSIB_F2_SRCOVP 6
`define CSIB_F2_SHORT 5
`define CSIB_F2_DIETEMP 4
`define CSIB_F2_BATTERY_TEMPERATURE_EVENT 3
`define CSIB_F2_BSTSHORT 2
`define CSIB_F2_SWOCP 1
`define CSIB_F2_TIMER 0

// Thermistor zone codes of interest
`define CSIB_NTC_COLDEST 4'h0
`define CSIB_NTC_COOL 4'h1
`define CSIB_NTC_WARM 4'h7
`define CSIB_NTC_HOTTEST 4'hF

// Timing: clock rate, watchdog and boost current-limit times
`define CSIB_CLK_HZ 32'd25000000
`define CSIB_WD_TIMEOUT_S 32'd100
`define CSIB_BST_LIMIT_US 32'd50
`define CSIB_US_PER_S 32'd1000000
`endif

// ==== verilog/csib_status_int.v ====
// Purpose: Status, clear-on-read event flags and mask logic of a charger
// Assumes: Event and condition inputs are synchronous to mclk
// Notes: Registers read and written over a simple strobed register port
// What this block does
// RQ1 - Status top bit shows source feeding power node
// RQ2 - Overvoltage sets status, halts switching, battery on
// RQ3 - Out-of-window battery temperature during charge sets status
// RQ4 - Zone 0000 or 1111 sets unsafe, stops charge
// RQ5 - Charge-mode watchdog expiry: status, defaults, enable cleared
// RQ6 - Enable set or reinsertion clears watchdog status
// RQ7 - Safety timer expiry status, cleared by reinsertion
// RQ8 - Flags reset zero, clear on read; validation fail
// RQ9 - Secondary source flag, suppressed while bus present
// RQ10 - Good-battery crossing, charge start, removal above threshold
// RQ11 - Charge done flag; pre/fast phase change flag
// RQ12 - Weak battery flag at plug-in below minimum
// RQ13 - Battery presence change flag
// RQ14 - Low-current crossing flag when termination disabled
// RQ15 - Recharge-needed flag after charge completes
// RQ16 - Boost overvoltage, overtemp, fail, undervoltage, watchdog flags
// RQ17 - Boost low-battery flag; boost continues until lockout
// RQ18 - Top-off complete flag with termination and top-off
// RQ19 - Overvoltage change, short battery, short check, overcurrent flags
// RQ20 - Die temperature flag; regulation and shutdown status bits
// RQ21 - Timer flag on safety or watchdog expiry
// RQ22 - Mask register read-write, resets zero, gates pin; here mask0 gates only flags0, flags1 and flags2 always pull
// RQ23 - Interrupt pin low while any unmasked flag set
`include "csib_consts.vh"

module csib_status_int #(
  parameter [31:0] WD_CYCLES = `CSIB_WD_TIMEOUT_S * `CSIB_CLK_HZ,
  parameter [31:0] BST_LIMIT_CYCLES =
    (`CSIB_BST_LIMIT_US * `CSIB_CLK_HZ + `CSIB_US_PER_S - 32'd1) / `CSIB_US_PER_S
) (
  input wire mclk,
  input wire resetn,
  // Register port
  input wire [7:0] regAddr,
  input wire regRead,
  input wire regWrite,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  output reg regRvalid,
  // Source conditions
  input wire busPresent,
  input wire secondaryPresent,
  input wire secondarySelected,
  input wire busOvervoltage,
  input wire secondaryOvervoltage,
  input wire sourceValidationFail,
  // Charger state
  input wire charging,
  input wire chargeMode,
  input wire preCharge,
  input wire chargeComplete,
  input wire chargeCycleDone,
  input wire terminationEnable,
  input wire topoffEnable,
  input wire topoffTimerExpire,
  input wire safetyTimerExpire,
  input wire lowCurrentStatus,
  input wire rechargeDrop,
  // Battery conditions
  input wire [3:0] thermistorZone,
  input wire batteryAboveGood,
  input wire [2:0] batteryLevel,
  input wire [2:0] batteryMinimumLevel,
  input wire batteryAbsent,
  input wire batteryBelowShort,
  input wire batteryBelow3v,
  input wire batteryBelowBoostLockout,
  input wire batterySwitchOvercurrent,
  // Die temperature
  input wire dieThermalRegulation,
  input wire dieThermalShutdown,
  // Boost conditions
  input wire boostEnable,
  input wire boostMode,
  input wire boostOvervoltage,
  input wire boostOvertemperature,
  input wire boostVoltageFail,
  input wire boostCurrentLimit,
  input wire boostShortCheckFail,
  // Watchdog control
  input wire watchdogEnableSet,
  input wire watchdogKick,
  // Outputs
  output reg watchdogEnable,
  output reg registersToDefault,
  output reg haltSwitching,
  output reg batterySwitchOn,
  output reg chargeReduce,
  output reg chargeStop,
  output reg boostRun,
  output wire intN
);

  reg [7:0] status;
  reg [7:0] flags0;
  reg [7:0] flags1;
  reg [7:0] flags2;
  reg [7:0] mask0;
  reg prevBus;
  reg prevSec;
  reg prevCharging;
  reg prevPre;
  reg prevGood;
  reg prevAbsent;
  reg prevLowCur;
  reg prevRechg;
  reg prevOvp;
  reg prevShort;
  reg prevLow3v;
  reg prevTreg;
  reg prevTshut;
  reg prevTwin;
  reg [31:0] wdCount;
  reg [31:0] limitCount;

  wire anyPresent = busPresent | secondaryPresent;
  wire srcOvp = busOvervoltage | secondaryOvervoltage;
  wire busRise = busPresent & ~prevBus;
  wire busFall = ~busPresent & prevBus;
  wire secRise = secondaryPresent & ~prevSec;
  wire secFall = ~secondaryPresent & prevSec;
  wire reinsert = busRise | secRise;
  wire plugIn = reinsert;
  wire removal = busFall | secFall;
  wire zoneUnsafe = (thermistorZone == `CSIB_NTC_COLDEST) |
                    (thermistorZone == `CSIB_NTC_HOTTEST);
  wire zoneOut = zoneUnsafe | (thermistorZone == `CSIB_NTC_COOL) |
                 (thermistorZone == `CSIB_NTC_WARM);
  wire tempOut = charging & zoneOut;
  wire wdRun = watchdogEnable & (chargeMode | boostMode);
  wire wdExpire = wdRun & (wdCount >= WD_CYCLES - 32'd1);
  wire limitExpire = boostMode & boostCurrentLimit &
                     (limitCount >= BST_LIMIT_CYCLES - 32'd1);

  // Clear masks for reads of the flag registers
  wire clr0 = regRead & (regAddr == `CSIB_ADDR_FLAGS0);
  wire clr1 = regRead & (regAddr == `CSIB_ADDR_FLAGS1);
  wire clr2 = regRead & (regAddr == `CSIB_ADDR_FLAGS2);

  // New events for each flag register
  reg [7:0] set0;
  reg [7:0] set1;
  reg [7:0] set2;

  always @* begin
    set0 = 8'h00;
    set1 = 8'h00;
    set2 = 8'h00;
    set0[`CSIB_F0_SOURCE_VALIDATION_FAIL] = sourceValidationFail; // RQ8
    // Secondary edges count only without bus; bus leaving hands over
    set0[`CSIB_F0_SECSRC] = ((secRise | secFall) & ~busPresent & ~busFall) |
                            (busFall & secondaryPresent); // RQ9
    set0[`CSIB_F0_BUSSRC] = busRise | busFall;
    set0[`CSIB_F0_GOODBAT] = (charging & (batteryAboveGood ^ prevGood)) |
                             (charging & ~prevCharging & batteryAboveGood) |
                             (removal & batteryAboveGood); // RQ10
    set0[`CSIB_F0_CHGDONE] = chargeCycleDone & terminationEnable; // RQ11
    set0[`CSIB_F0_PHASE] = charging & prevCharging & (preCharge ^ prevPre); // RQ11
    set0[`CSIB_F0_WEAKBAT] = plugIn & (batteryLevel < batteryMinimumLevel); // RQ12
    set0[`CSIB_F0_BATPRES] = batteryAbsent ^ prevAbsent; // RQ13
    set1[`CSIB_F1_LOWCUR] = ~terminationEnable & (lowCurrentStatus ^ prevLowCur); // RQ14
    set1[`CSIB_F1_RECHG] = chargeComplete & rechargeDrop & ~prevRechg; // RQ15
    set1[`CSIB_F1_BOOST_OVERVOLTAGE] = boostMode & boostOvervoltage; // RQ16
    set1[`CSIB_F1_BSTOTP] = boostMode & boostOvertemperature; // RQ16
    set1[`CSIB_F1_BOOST_REGULATION_FAIL] = boostMode & (boostVoltageFail | limitExpire); // RQ16
    set1[`CSIB_F1_BSTUV] = boostMode & batteryBelowBoostLockout; // RQ16
    set1[`CSIB_F1_BSTWD] = wdExpire & boostMode; // RQ16
    set1[`CSIB_F1_BSTLOW] = boostMode & batteryBelow3v & ~prevLow3v; // RQ17
    set2[`CSIB_F2_TOPOFF] = topoffTimerExpire & terminationEnable & topoffEnable; // RQ18
    set2[`CSIB_F2_SRCOVP] = srcOvp ^ prevOvp; // RQ19
    set2[`CSIB_F2_SHORT] = charging & batteryBelowShort & ~prevShort; // RQ19
    set2[`CSIB_F2_DIETEMP] = (dieThermalRegulation & ~prevTreg) |
                             (dieThermalShutdown & ~prevTshut); // RQ20
    set2[`CSIB_F2_BATTERY_TEMPERATURE_EVENT] = tempOut & ~prevTwin;
    set2[`CSIB_F2_BSTSHORT] = boostShortCheckFail; // RQ19
    set2[`CSIB_F2_SWOCP] = batterySwitchOvercurrent; // RQ19
    set2[`CSIB_F2_TIMER] = safetyTimerExpire | wdExpire; // RQ21
  end

  // Previous values for edge detection
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prevBus <= 1'b0;
      prevSec <= 1'b0;
      prevCharging <= 1'b0;
      prevPre <= 1'b0;
      prevGood <= 1'b0;
      prevAbsent <= 1'b0;
      prevLowCur <= 1'b0;
      prevRechg <= 1'b0;
      prevOvp <= 1'b0;
      prevShort <= 1'b0;
      prevLow3v <= 1'b0;
      prevTreg <= 1'b0;
      prevTshut <= 1'b0;
      prevTwin <= 1'b0;
    end else begin
      prevBus <= busPresent;
      prevSec <= secondaryPresent;
      prevCharging <= charging;
      prevPre <= preCharge;
      prevGood <= batteryAboveGood;
      prevAbsent <= batteryAbsent;
      prevLowCur <= lowCurrentStatus;
      prevRechg <= rechargeDrop;
      prevOvp <= srcOvp;
      prevShort <= batteryBelowShort;
      prevLow3v <= batteryBelow3v;
      prevTreg <= dieThermalRegulation;
      prevTshut <= dieThermalShutdown;
      prevTwin <= tempOut;
    end
  end

  // Event flags: a new event wins over a read clear in the same cycle
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags0 <= `CSIB_FLAGS_RESET; // RQ8
      flags1 <= `CSIB_FLAGS_RESET;
      flags2 <= `CSIB_FLAGS_RESET;
    end else begin
      flags0 <= (flags0 & {8{~clr0}}) | set0; // RQ8
      flags1 <= (flags1 & {8{~clr1}}) | set1; // RQ8
      flags2 <= (flags2 & {8{~clr2}}) | set2; // RQ8
    end
  end

  // Mask register; watchdog expiry in charge returns it to default
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask0 <= `CSIB_MASK_RESET; // RQ22
    end else if (wdExpire & chargeMode) begin
      mask0 <= `CSIB_MASK_RESET; // RQ5
    end else if (regWrite & (regAddr == `CSIB_ADDR_MASK0)) begin
      mask0 <= regWdata; // RQ22
    end
  end

  // Watchdog counter; kicked or disabled it starts over
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wdCount <= 32'h0000_0000;
      watchdogEnable <= 1'b0;
      registersToDefault <= 1'b0;
    end else begin
      registersToDefault <= wdExpire & chargeMode; // RQ5
      if (!wdRun || watchdogKick || wdExpire) begin
        wdCount <= 32'h0000_0000;
      end else begin
        wdCount <= wdCount + 32'h0000_0001;
      end
      // A host set in the expiry cycle re-arms the watchdog
      if (watchdogEnableSet) begin
        watchdogEnable <= 1'b1;
      end else if (wdExpire & chargeMode) begin
        watchdogEnable <= 1'b0; // RQ5
      end
    end
  end

  // Boost current-limit duration; any break in the limit restarts it
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      limitCount <= 32'h0000_0000;
    end else if (!(boostMode & boostCurrentLimit) || limitExpire) begin
      limitCount <= 32'h0000_0000;
    end else begin
      limitCount <= limitCount + 32'h0000_0001; // RQ16
    end
  end

  // Status register; sticky timeout bits follow the set-wins order
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status <= `CSIB_STATUS_RESET;
    end else begin
      // Under overvoltage the select bit names the offending input
      if (srcOvp) begin
        status[`CSIB_ST_SRCSEL] <= secondaryOvervoltage & ~busOvervoltage; // RQ2
      end else if (anyPresent) begin
        status[`CSIB_ST_SRCSEL] <= secondarySelected; // RQ1
      end
      status[`CSIB_ST_SRCOVP] <= srcOvp; // RQ2
      status[`CSIB_ST_TSHUT] <= dieThermalShutdown; // RQ20
      status[`CSIB_ST_TREG] <= dieThermalRegulation; // RQ20
      status[`CSIB_ST_TWIN] <= tempOut; // RQ3
      status[`CSIB_ST_TUNSAFE] <= zoneUnsafe; // RQ4
      if (wdExpire & chargeMode) begin
        status[`CSIB_ST_WDTO] <= 1'b1; // RQ5
      end else if (watchdogEnableSet | reinsert) begin
        status[`CSIB_ST_WDTO] <= 1'b0; // RQ6
      end
      if (safetyTimerExpire) begin
        status[`CSIB_ST_SAFETO] <= 1'b1; // RQ7
      end else if (reinsert) begin
        status[`CSIB_ST_SAFETO] <= 1'b0; // RQ7
      end
    end
  end

  // Power-stage controls derived from protection conditions
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      haltSwitching <= 1'b0;
      batterySwitchOn <= 1'b0;
      chargeReduce <= 1'b0;
      chargeStop <= 1'b0;
      boostRun <= 1'b0;
    end else begin
      haltSwitching <= srcOvp; // RQ2
      batterySwitchOn <= srcOvp; // RQ2
      chargeReduce <= tempOut & ~zoneUnsafe; // RQ3
      chargeStop <= zoneUnsafe; // RQ4
      // Low battery only flags; the lockout alone ends boost
      boostRun <= boostEnable & ~batteryBelowBoostLockout; // RQ17
    end
  end

  // Read data; unmapped offsets read as zero, answer one cycle later
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        case (regAddr)
          `CSIB_ADDR_STATUS: regRdata <= status;
          `CSIB_ADDR_FLAGS0: regRdata <= flags0;
          `CSIB_ADDR_FLAGS1: regRdata <= flags1;
          `CSIB_ADDR_FLAGS2: regRdata <= flags2;
          `CSIB_ADDR_MASK0: regRdata <= mask0;
          default: regRdata <= 8'h00;
        endcase
      end
    end
  end

  // Only the first flag register has its mask here; the others always pull
  assign intN = ~(|(flags0 & ~mask0) | (|flags1) | (|flags2)); // RQ23
endmodule

// ==== test/csib_properties.sv ====
// Purpose: Concurrent checks on the register port and pin of the status bank
// Assumes: Reads and writes never share a cycle
// Notes: Status checks wait for quiet inputs, since status lags one cycle
module csib_properties (
  input logic mclk,
  input logic resetn,
  input logic [7:0] regAddr,
  input logic regRead,
  input logic regWrite,
  input logic [7:0] regWdata,
  input logic [7:0] regRdata,
  input logic regRvalid,
  input logic busPresent,
  input logic secondaryPresent,
  input logic secondarySelected,
  input logic busOvervoltage,
  input logic secondaryOvervoltage,
  input logic sourceValidationFail,
  input logic charging,
  input logic [3:0] thermistorZone,
  input logic dieThermalRegulation,
  input logic dieThermalShutdown,
  input logic registersToDefault,
  input logic haltSwitching,
  input logic batterySwitchOn,
  input logic intN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [7:0] maskCopy;
  logic [11:0] obsP1;
  logic [11:0] obsP2;
  wire [11:0] obs = {resetn, thermistorZone, charging, dieThermalShutdown,
    dieThermalRegulation, secondarySelected, busOvervoltage, secondaryOvervoltage,
    busPresent | secondaryPresent};
  wire steady = (obs == obsP1) && (obsP1 == obsP2);
  // Input history; reset is part of it so a fresh release never looks settled
  always @(posedge mclk) begin
    obsP1 <= obs;
    obsP2 <= obsP1;
  end
  // Shadow of the mask register; a watchdog default return wipes it too
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      maskCopy <= 8'h00;
    end else if (registersToDefault) begin
      maskCopy <= 8'h00;
    end else if (regWrite && regAddr == 8'h08) begin
      maskCopy <= regWdata;
    end
  end
  // Status read with every watched input quiet for two cycles
  sequence s_status_read;
    regRead && regAddr == 8'h02 && steady;
  endsequence
  sequence s_window_read;
    s_status_read ##0 charging;
  endsequence
  a_read_answer: assert property (regRead |=> regRvalid)
    else $error("read without answer strobe");
  a_no_spurious: assert property (!regRead |=> !regRvalid)
    else $error("answer strobe without read");
  a_mask_readback: assert property (regRead && regAddr == 8'h08 && !registersToDefault
    |=> regRdata == $past(maskCopy)) else $error("mask read differs from writes");
  a_pin_event: assert property (sourceValidationFail && !maskCopy[7] && !registersToDefault
    && !(regWrite && regAddr == 8'h08) |=> !intN) else $error("unmasked event left pin high");
  a_source_select: assert property (s_status_read ##0 (busPresent || secondaryPresent)
    && !busOvervoltage && !secondaryOvervoltage |=> regRdata[7] == $past(secondarySelected))
    else $error("source select bit wrong");
  a_ovp_status: assert property (s_status_read ##0 (busOvervoltage || secondaryOvervoltage)
    |=> regRdata[6] && haltSwitching && batterySwitchOn
    && (regRdata[7] == ($past(secondaryOvervoltage) && !$past(busOvervoltage))))
    else $error("overvoltage reaction wrong");
  a_temp_window: assert property (s_window_read |=> regRdata[3] ==
    ($past(thermistorZone) inside {4'h0, 4'h1, 4'h7, 4'hF})) else $error("window bit wrong");
  a_temp_unsafe: assert property (s_window_read |=> regRdata[2] ==
    ($past(thermistorZone) inside {4'h0, 4'hF})) else $error("unsafe bit wrong");
  a_die_status: assert property (s_status_read |=> regRdata[5:4] ==
    $past({dieThermalShutdown, dieThermalRegulation})) else $error("die status bits wrong");
endmodule
bind csib_status_int csib_properties u_props (.mclk(mclk), .resetn(resetn),
  .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata),
  .regRdata(regRdata), .regRvalid(regRvalid), .busPresent(busPresent),
  .secondaryPresent(secondaryPresent), .secondarySelected(secondarySelected),
  .busOvervoltage(busOvervoltage), .secondaryOvervoltage(secondaryOvervoltage),
  .sourceValidationFail(sourceValidationFail), .charging(charging),
  .thermistorZone(thermistorZone), .dieThermalRegulation(dieThermalRegulation),
  .dieThermalShutdown(dieThermalShutdown), .registersToDefault(registersToDefault),
  .haltSwitching(haltSwitching), .batterySwitchOn(batterySwitchOn), .intN(intN));

// ==== test/csib_host_model.sv ====
// Purpose: Host processor side of the register port
// Assumes: One request at a time, answer strobe one cycle after a read
// Notes: Idle address and data are inverted so stale values never look valid
module csib_host_model (
  input wire logic mclk,
  output logic [7:0] regAddr,
  output logic regRead,
  output logic regWrite,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet port at time zero
  initial begin
    regAddr = 8'h00;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWdata = 8'h00;
  end
  // One write cycle, launched on a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge mclk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  // One read; a missing answer comes back unknown so the compare fails
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge mclk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge mclk);
    regRead = 1'b0;
    regAddr = ~a;
    n = 0;
    while (regRvalid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    d = (regRvalid === 1'b1) ? regRdata : 8'hxx;
  endtask
endmodule

// ==== test/testbench.sv ====
// Purpose: Self-checking bench of the charger status and interrupt bank
// Assumes: Inputs change on falling edges; short watchdog and limit counts
// Notes: Single-bit inputs live in one vector so a table can drive them
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic resetn;
  logic [33:0] pin;
  logic [3:0] thermistorZone;
  logic [2:0] batteryLevel;
  logic [2:0] batteryMinimumLevel;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic regRead;
  logic regWrite;
  logic regRvalid;
  logic watchdogEnable;
  logic registersToDefault;
  logic chargeStop;
  logic chargeReduce;
  logic boostRun;
  logic intN;
  int num_errors = 0;
  int num_checks = 0;
  // Entries: input index, value (2 means one-cycle pulse), read offset, expected byte
  logic [31:0] steps [$] = {
    32'h0002_0480, 32'h0102_0408, 32'h0202_0680, 32'h0302_0602,
    32'h0402_0604, 32'h0501_0401, 32'h0500_0401, 32'h1301_0400,
    32'h0601_0404, 32'h0600_0404, 32'h0901_0410, 32'h1F01_0620,
    32'h1F00_FF00, 32'h1600_FF00, 32'h0102_0400, 32'h0701_0580, 32'h0700_0580,
    32'h1601_FF00, 32'h1701_FF00, 32'h0801_0540, 32'h0800_FF00,
    32'h1700_FF00, 32'h1300_0400, 32'h0900_0400, 32'h1401_FF00,
    32'h0A02_0520, 32'h0B02_0510, 32'h0C02_0508, 32'h0D02_0504,
    32'h0E01_0501, 32'h0E00_FF00, 32'h1400_FF00, 32'h1101_0440,
    32'h1E01_0280, 32'h1201_0420, 32'h1E00_0200, 32'h0F01_0240,
    32'h0F00_0640, 32'h1001_02C0, 32'h1000_0640, 32'h1100_0400,
    32'h1101_0400, 32'h1200_0460, 32'h3001_FF00, 32'h1201_0422,
    32'h3003_FF00, 32'h1802_0201, 32'hFF00_0601, 32'h1100_FF00,
    32'h1101_0200, 32'h1901_0220, 32'hFF00_0610, 32'h1900_FF00,
    32'h1A01_0210, 32'hFF00_0610, 32'h1A00_FF00,
    32'h1B00_FF00, 32'h0202_0600, 32'h1B01_FF00};
  csib_status_int #(.WD_CYCLES(32'h0000_0032), .BST_LIMIT_CYCLES(32'h0000_0004)) dut (
    .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .busPresent(pin[18]), .secondaryPresent(pin[17]), .secondarySelected(pin[30]),
    .busOvervoltage(pin[15]), .secondaryOvervoltage(pin[16]),
    .sourceValidationFail(pin[0]), .charging(pin[19]), .chargeMode(pin[21]),
    .preCharge(pin[6]), .chargeComplete(pin[23]), .chargeCycleDone(pin[1]),
    .terminationEnable(pin[22]), .topoffEnable(pin[27]), .topoffTimerExpire(pin[2]),
    .safetyTimerExpire(pin[24]), .lowCurrentStatus(pin[7]), .rechargeDrop(pin[8]),
    .thermistorZone(thermistorZone), .batteryAboveGood(pin[9]),
    .batteryLevel(batteryLevel), .batteryMinimumLevel(batteryMinimumLevel),
    .batteryAbsent(pin[5]), .batteryBelowShort(pin[31]), .batteryBelow3v(pin[14]),
    .batteryBelowBoostLockout(pin[13]), .batterySwitchOvercurrent(pin[3]),
    .dieThermalRegulation(pin[26]), .dieThermalShutdown(pin[25]),
    .boostEnable(pin[29]), .boostMode(pin[20]), .boostOvervoltage(pin[10]),
    .boostOvertemperature(pin[11]), .boostVoltageFail(pin[12]),
    .boostCurrentLimit(pin[28]), .boostShortCheckFail(pin[4]),
    .watchdogEnableSet(pin[32]), .watchdogKick(pin[33]), .watchdogEnable(watchdogEnable),
    .registersToDefault(registersToDefault), .haltSwitching(), .batterySwitchOn(),
    .chargeReduce(chargeReduce), .chargeStop(chargeStop), .boostRun(boostRun), .intN(intN));
  csib_host_model host (.mclk(mclk), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
  // Free-running 25 MHz clock
  always #20ns mclk = ~mclk;
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  // Index 8'h30 is the battery level code; out-of-range indexes change nothing
  task automatic poke(input logic [7:0] k, input logic [7:0] v);
    if (k == 8'h30) begin
      batteryLevel = v[2:0];
    end else if (k < 8'd34) begin
      pin[k] = v[0] | v[1];
    end
    if (v[1] && k < 8'd34) begin
      @(negedge mclk);
      pin[k] = 1'b0;
    end
  endtask
  task automatic t_reset();
    logic [7:0] regs [$] = {8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h03};
    chk("intN", {7'h0, intN}, 8'h01);
    foreach (regs[i]) rc(regs[i], 8'h00);
  endtask
  task automatic t_pin();
    host.wr(8'h08, 8'hA5);
    rc(8'h08, 8'hA5);
    host.wr(8'h08, 8'h80);
    poke(8'h00, 8'h02);
    @(negedge mclk);
    chk("intN", {7'h0, intN}, 8'h01);
    host.wr(8'h08, 8'h00);
    chk("intN", {7'h0, intN}, 8'h00);
    rc(8'h04, 8'h80);
    chk("intN", {7'h0, intN}, 8'h01);
    host.wr(8'h04, 8'hFF);
    rc(8'h04, 8'h00);
    poke(8'h03, 8'h02);
    @(negedge mclk);
    chk("intN", {7'h0, intN}, 8'h00);
    rc(8'h06, 8'h02);
  endtask
  task automatic t_events();
    foreach (steps[i]) begin
      poke(steps[i][31:24], steps[i][23:16]);
      repeat (2) @(negedge mclk);
      rc(steps[i][15:8], steps[i][7:0]);
    end
  endtask
  task automatic t_zones();
    pin[19] = 1'b1;
    for (int z = 0; z < 16; z++) begin
      thermistorZone = z[3:0];
      repeat (3) @(negedge mclk);
      rc(8'h02, {4'h0, z == 0 || z == 1 || z == 7 || z == 15, z == 0 || z == 15, 2'b00});
      chk("chargeStop", {7'h0, chargeStop}, {7'h0, z == 0 || z == 15});
      chk("chargeReduce", {7'h0, chargeReduce}, {7'h0, z == 1 || z == 7});
    end
    thermistorZone = 4'h3;
    pin[19] = 1'b0;
    rc(8'h06, 8'h08);
  endtask
  // Three cycles of current limit is below the limit count, five is above it
  task automatic t_boost();
    pin[20] = 1'b1;
    for (int h = 3; h < 6; h += 2) begin
      pin[28] = 1'b1;
      repeat (h) @(negedge mclk);
      pin[28] = 1'b0;
      rc(8'h05, (h > 4) ? 8'h08 : 8'h00);
    end
    pin[14] = 1'b1;
    repeat (3) @(negedge mclk);
    chk("boostRun", {7'h0, boostRun}, 8'h01);
    pin[13] = 1'b1;
    repeat (3) @(negedge mclk);
    chk("boostRun", {7'h0, boostRun}, 8'h00);
    pin[13] = 1'b0;
    pin[14] = 1'b0;
    pin[20] = 1'b0;
    rc(8'h05, 8'h05);
  endtask
  task automatic t_watchdog();
    int n;
    host.wr(8'h08, 8'h01);
    pin[21] = 1'b1;
    poke(8'h20, 8'h02);
    @(negedge mclk);
    chk("wdEnable", {7'h0, watchdogEnable}, 8'h01);
    n = 0;
    while (registersToDefault !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    pin[21] = 1'b0;
    chk("wdEnable", {7'h0, watchdogEnable}, 8'h00);
    rc(8'h08, 8'h00);
    rc(8'h02, 8'h02);
    rc(8'h06, 8'h01);
    poke(8'h20, 8'h02);
    @(negedge mclk);
    rc(8'h02, 8'h00);
    // A kick restarts the count, so the read after it still sees no expiry
    pin[20] = 1'b1;
    repeat (40) @(negedge mclk);
    poke(8'h21, 8'h02);
    repeat (40) @(negedge mclk);
    rc(8'h05, 8'h00);
    repeat (20) @(negedge mclk);
    pin[20] = 1'b0;
    rc(8'h05, 8'h02);
    rc(8'h06, 8'h01);
    chk("wdEnable", {7'h0, watchdogEnable}, 8'h01);
  endtask
  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard at 20000 cycles, far beyond the under one thousand cycles the run needs
  initial begin
    #800us;
    num_errors++;
    finish_test();
  end
  // Terminating and top-off enabled, boost allowed, battery level at its minimum
  initial begin
    pin = '0;
    pin[22] = 1'b1;
    pin[27] = 1'b1;
    pin[29] = 1'b1;
    thermistorZone = 4'h3;
    batteryLevel = 3'h3;
    batteryMinimumLevel = 3'h3;
    mclk = 1'b0;
    resetn = 1'b0;
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    t_reset();
    t_pin();
    t_events();
    t_zones();
    t_boost();
    t_watchdog();
    finish_test();
  end
endmodule
